// file: jrx_pkg.sv
// Purpose: Shared constants for the receive lane status and sync control block
// Assumes: APB byte address is four times the register index
// Notes: All offsets, field positions, reset values and timing counts live here

package jrx_pkg;

    // ****************************************************************
    // Register indexes (byte address = index * 4)
    // ****************************************************************
    localparam logic [9:0] IDX_XBAR_0_1 = 10'h308;
    localparam logic [9:0] IDX_XBAR_2_3 = 10'h309;
    localparam logic [9:0] IDX_XBAR_4_5 = 10'h30A;
    localparam logic [9:0] IDX_XBAR_6_7 = 10'h30B;
    localparam logic [9:0] IDX_FIFO_FULL = 10'h30C;
    localparam logic [9:0] IDX_FIFO_EMPTY = 10'h30D;
    localparam logic [9:0] IDX_SYNC_MASK = 10'h311;
    localparam logic [9:0] IDX_SYNC_DUR = 10'h312;
    localparam logic [9:0] IDX_MF_PERIOD = 10'h313;
    localparam logic [9:0] IDX_TEST_EN = 10'h315;
    localparam logic [9:0] IDX_TEST_CTRL = 10'h316;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h320;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h321;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FRAME_MASK_BIT = 0;
    localparam int MF_MASK_BIT = 2;
    localparam int ERR_DUR_LSB = 4;
    localparam int SYNC_DUR_LSB = 0;
    localparam int LANE_SEL_LSB = 4;
    localparam int XBAR_ODD_LSB = 3;
    localparam int TEST_EN_BIT = 0;

    // Interrupt status bits
    localparam int IRQ_FRAME_LOSS = 0;
    localparam int IRQ_MF_LOSS = 1;
    localparam int IRQ_ERR_REPORT = 2;
    localparam int IRQ_FIFO_FULL = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [23:0] XBAR_RST = 24'hFA_C688;
    localparam logic [7:0] REG_RST = 8'h00;

    // ****************************************************************
    // Timing counts (octets and processing-clock cycles)
    // ****************************************************************
    localparam logic [8:0] OCTETS_PER_PCLK = 9'h004;
    localparam logic [8:0] SYNC_BASE_FRAMES = 9'h005;
    localparam logic [8:0] SYNC_EXTRA_OCTETS = 9'h009;
    localparam logic [7:0] ERR_BASE_CYCLES = 8'h01;
    localparam logic [7:0] PERIOD_MAX = 8'hFF;

endpackage

// file: jrx_lane_mux.sv
// Purpose: Registered eight-way word selector
// Assumes: Select code n picks input word n
// Notes: Used for the lane crossbar and the error count report

`timescale 1ns/100ps
`default_nettype none

module jrx_lane_mux #(
    parameter int W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] sel,
    input wire logic [8*W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] q;
    } jrx_mux_state_t;

    jrx_mux_state_t st;
    jrx_mux_state_t next_st;

    // Pick the word named by the code
    always_comb begin
        next_st = st;
        next_st.q = din[sel*W +: W]; // R10
    end

    // Register the choice so the output is a clean flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;

    AST_MUX_PICK: assert property (@(posedge pclk) disable iff (!presetn) // R10
        1'b1 |=> dout == $past(din[sel*W +: W]))
        else $error("Selector output does not follow its code");

endmodule

`default_nettype wire

// file: jrx_low_timer.sv
// Purpose: Holds a level for a loaded number of cycles
// Assumes: Load value is at least one
// Notes: A new start restarts the count

`timescale 1ns/100ps
`default_nettype none

module jrx_low_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [7:0] cycles,
    output logic active
);

    typedef struct packed {
        logic busy;
        logic [7:0] left;
    } jrx_timer_state_t;

    jrx_timer_state_t st;
    jrx_timer_state_t next_st;

    // Load on start, then count down to idle
    always_comb begin
        next_st = st;
        if (start) begin
            next_st.busy = 1'b1;
            next_st.left = cycles - 8'h01;
        end else if (st.busy) begin
            if (st.left == 8'h00) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.left = st.left - 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.busy;

endmodule

`default_nettype wire

// file: jrx_sync_status.sv
// Purpose: Receive lane status, sync request generation and lane routing
// Assumes: APB slave, zero wait states, all inputs synchronous to pclk
// Notes: Status flags are live; sync low timing is counted in pclk cycles
//
// Operation
// [R01] Full flag byte: bit n shows receive FIFO of physical lane n full.
// [R02] Empty flag byte: bit n shows receive FIFO of physical lane n empty.
// [R03] Multiframe loss pulls sync output low only when its enable bit is set.
// [R04] Frame loss pulls sync output low only when its enable bit is set.
// [R05] Error report low time: base half cycle plus one cycle per step; the code uses a base of one whole cycle.
// [R06] Sync request low time: five frames plus nine octets, plus cycles per step.
// [R07] Report multiframe clock period as count of processing-clock cycles.
// [R08] Test enable one ungates bit error test clocks; zero gates them.
// [R09] Three-bit selector picks which lane error count is reported.
// [R10] Each logical lane takes one physical lane by code; default is own number.
// [R11] Full and empty bits are read live, unlatched, reads have no effect.

`timescale 1ns/100ps
`default_nettype none

module jrx_sync_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] lane_fifo_full,
    input wire logic [7:0] lane_fifo_empty,
    input wire logic frame_align_loss,
    input wire logic multiframe_align_loss,
    input wire logic link_sync_request,
    input wire logic error_report,
    input wire logic [5:0] frame_octets,
    input wire logic lmfc_pulse,
    input wire logic [255:0] physical_serial_lane_input,
    output logic [255:0] logical_lane_data,
    input wire logic [191:0] lane_error_counts,
    output logic [23:0] selected_error_count,
    output logic bit_error_test_clock_enable,
    output logic sync_request_output_n,
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] prdata;
        logic slverr;
        logic [2:0] mask_ctrl;
        logic [7:0] dur_ctrl;
        logic [7:0] period_cnt;
        logic [7:0] period;
        logic [7:0] test_en;
        logic [6:0] test_ctrl;
        logic [23:0] xbar;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
    } jrx_state_t;

    jrx_state_t st;
    jrx_state_t next_st;

    logic [9:0] idx;
    logic setup;
    logic wr;
    logic hit;
    logic [7:0] rd;
    logic sync_start;
    logic err_start;
    logic timer_start;
    logic timer_active;
    logic [7:0] sync_cycles;
    logic [7:0] err_cycles;
    logic [7:0] load_cycles;
    logic [8:0] sync_octets;
    logic [3:0] events;

    assign idx = paddr[11:2];
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;

    // ****************************************************************
    // Sync request timing
    // ****************************************************************

    // Five frames plus nine octets, rounded up to whole pclk cycles
    assign sync_octets = jrx_pkg::SYNC_BASE_FRAMES * {3'b000, frame_octets}
        + jrx_pkg::SYNC_EXTRA_OCTETS;
    assign sync_cycles = 8'((sync_octets + jrx_pkg::OCTETS_PER_PCLK - 9'h001) >> 2)
        + {4'h0, st.dur_ctrl[jrx_pkg::SYNC_DUR_LSB +: 4]}; // R06

    // Half a cycle cannot be made on one clock, so the base rounds up to one
    assign err_cycles = jrx_pkg::ERR_BASE_CYCLES
        + {4'h0, st.dur_ctrl[jrx_pkg::ERR_DUR_LSB +: 4]}; // R05

    // Loss events only count when their enable bit is set
    assign sync_start = (frame_align_loss & st.mask_ctrl[jrx_pkg::FRAME_MASK_BIT]) // R04
        | (multiframe_align_loss & st.mask_ctrl[jrx_pkg::MF_MASK_BIT]) // R03
        | link_sync_request;

    // An error report never cuts short a pulse already running
    assign err_start = error_report & ~sync_start & ~timer_active;
    assign timer_start = sync_start | err_start;
    assign load_cycles = sync_start ? sync_cycles : err_cycles;

    jrx_low_timer u_low_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(timer_start),
        .cycles(load_cycles),
        .active(timer_active)
    );

    // Active low request pin toward the transmitter
    assign sync_request_output_n = ~timer_active;

    // ****************************************************************
    // Lane crossbar and error count report
    // ****************************************************************

    // One selector per logical lane
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_xbar
            jrx_lane_mux #(.W(32)) u_lane_mux (
                .pclk(pclk),
                .presetn(presetn),
                .sel(st.xbar[3*g +: 3]),
                .din(physical_serial_lane_input),
                .dout(logical_lane_data[32*g +: 32])
            ); // R10
        end
    endgenerate

    // Error count of the lane named by the selector
    jrx_lane_mux #(.W(24)) u_err_mux (
        .pclk(pclk),
        .presetn(presetn),
        .sel(st.test_ctrl[jrx_pkg::LANE_SEL_LSB +: 3]),
        .din(lane_error_counts),
        .dout(selected_error_count)
    ); // R09

    // Clock gate control for the bit error test logic
    assign bit_error_test_clock_enable = st.test_en[jrx_pkg::TEST_EN_BIT]; // R08

    // ****************************************************************
    // Register read decode
    // ****************************************************************

    // Status bytes come straight from the FIFOs, so a read never disturbs them
    always_comb begin
        hit = 1'b1;
        rd = 8'h00;
        case (idx)
            jrx_pkg::IDX_XBAR_0_1: rd = {2'b00, st.xbar[5:0]};
            jrx_pkg::IDX_XBAR_2_3: rd = {2'b00, st.xbar[11:6]};
            jrx_pkg::IDX_XBAR_4_5: rd = {2'b00, st.xbar[17:12]};
            jrx_pkg::IDX_XBAR_6_7: rd = {2'b00, st.xbar[23:18]};
            jrx_pkg::IDX_FIFO_FULL: rd = lane_fifo_full; // R01 R11
            jrx_pkg::IDX_FIFO_EMPTY: rd = lane_fifo_empty; // R02 R11
            jrx_pkg::IDX_SYNC_MASK: rd = {5'h00, st.mask_ctrl};
            jrx_pkg::IDX_SYNC_DUR: rd = st.dur_ctrl;
            jrx_pkg::IDX_MF_PERIOD: rd = st.period; // R07
            jrx_pkg::IDX_TEST_EN: rd = st.test_en;
            jrx_pkg::IDX_TEST_CTRL: rd = {1'b0, st.test_ctrl};
            jrx_pkg::IDX_IRQ_STATUS: rd = {4'h0, st.irq_status};
            jrx_pkg::IDX_IRQ_MASK: rd = {4'h0, st.irq_mask};
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Events that can raise the interrupt
    assign events = {|lane_fifo_full, err_start, multiframe_align_loss, frame_align_loss};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;

        // Read data is caught in the setup cycle so the access phase needs no wait
        if (setup) begin
            next_st.prdata = pwrite ? 8'h00 : rd;
            next_st.slverr = ~hit;
        end

        // Register writes take effect in the access phase
        if (wr && hit) begin
            case (idx)
                jrx_pkg::IDX_XBAR_0_1: next_st.xbar[5:0] = pwdata[5:0]; // R10
                jrx_pkg::IDX_XBAR_2_3: next_st.xbar[11:6] = pwdata[5:0];
                jrx_pkg::IDX_XBAR_4_5: next_st.xbar[17:12] = pwdata[5:0];
                jrx_pkg::IDX_XBAR_6_7: next_st.xbar[23:18] = pwdata[5:0];
                jrx_pkg::IDX_SYNC_MASK: next_st.mask_ctrl = pwdata[2:0]; // R03 R04
                jrx_pkg::IDX_SYNC_DUR: next_st.dur_ctrl = pwdata[7:0]; // R05 R06
                jrx_pkg::IDX_TEST_EN: next_st.test_en = pwdata[7:0]; // R08
                jrx_pkg::IDX_TEST_CTRL: next_st.test_ctrl = pwdata[6:0]; // R09
                jrx_pkg::IDX_IRQ_MASK: next_st.irq_mask = pwdata[3:0];
                default: begin
                end
            endcase
        end

        // Write one to clear; a new event in the same cycle wins
        if (wr && idx == jrx_pkg::IDX_IRQ_STATUS) begin
            next_st.irq_status = st.irq_status & ~pwdata[3:0];
        end
        next_st.irq_status = next_st.irq_status | events;

        // Period between multiframe ticks, saturating so a long gap reads full scale at the next tick
        if (lmfc_pulse) begin
            next_st.period = (st.period_cnt == jrx_pkg::PERIOD_MAX) ? jrx_pkg::PERIOD_MAX
                : st.period_cnt + 8'h01; // R07
            next_st.period_cnt = 8'h00;
        end else if (st.period_cnt != jrx_pkg::PERIOD_MAX) begin
            next_st.period_cnt = st.period_cnt + 8'h01;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.xbar <= jrx_pkg::XBAR_RST;
            st.dur_ctrl <= jrx_pkg::REG_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Bus and interrupt outputs
    // ****************************************************************

    // Zero wait states; error only for unmapped addresses
    assign pready = 1'b1;
    assign pslverr = psel & penable & st.slverr;
    assign prdata = {24'h00_0000, st.prdata};

    // Level interrupt while any unmasked status bit is set
    assign irq = |(st.irq_status & st.irq_mask);

    // ****************************************************************
    // Checks
    // ****************************************************************

    AST_FULL_FLAGS: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (setup && !pwrite && idx == jrx_pkg::IDX_FIFO_FULL)
        |=> prdata[7:0] == $past(lane_fifo_full) && prdata[31:8] == 24'h00_0000)
        else $error("Full flag byte does not show the FIFO full inputs");

    AST_EMPTY_FLAGS: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (setup && !pwrite && idx == jrx_pkg::IDX_FIFO_EMPTY)
        |=> prdata[7:0] == $past(lane_fifo_empty))
        else $error("Empty flag byte does not show the FIFO empty inputs");

    AST_LIVE_READ: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (setup && !pwrite && idx == jrx_pkg::IDX_FIFO_FULL) ##3
        (setup && !pwrite && idx == jrx_pkg::IDX_FIFO_FULL)
        |=> prdata[7:0] == $past(lane_fifo_full))
        else $error("Repeated status read shows a stale value");

    AST_MF_SYNC: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (multiframe_align_loss && st.mask_ctrl[jrx_pkg::MF_MASK_BIT])
        |=> !sync_request_output_n)
        else $error("Enabled multiframe loss did not pull sync low");

    AST_FRAME_SYNC: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (frame_align_loss && st.mask_ctrl[jrx_pkg::FRAME_MASK_BIT])
        |=> !sync_request_output_n)
        else $error("Enabled frame loss did not pull sync low");

    AST_MASKED_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (!timer_active && !link_sync_request && !error_report
        && !(frame_align_loss && st.mask_ctrl[jrx_pkg::FRAME_MASK_BIT])
        && !(multiframe_align_loss && st.mask_ctrl[jrx_pkg::MF_MASK_BIT]))
        |=> sync_request_output_n)
        else $error("Sync went low without an enabled cause");

    AST_ERR_DUR: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (err_start && st.dur_ctrl[7:4] == 4'h1) ##1 (!sync_start && !timer_start)[*2]
        |-> !sync_request_output_n ##1 sync_request_output_n)
        else $error("Error report low time is not two cycles for step one");

    AST_SYNC_DUR: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (sync_start && frame_octets == 6'h04 && st.dur_ctrl[3:0] == 4'h0)
        |=> (!sync_request_output_n)[*8])
        else $error("Sync request low time is shorter than eight cycles");

    AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn) // R07
        lmfc_pulse ##1 (!lmfc_pulse)[*5] ##1 lmfc_pulse |=> st.period == 8'h06)
        else $error("Multiframe period not reported as six cycles");

    AST_TEST_EN: assert property (@(posedge pclk) disable iff (!presetn) // R08
        (wr && idx == jrx_pkg::IDX_TEST_EN)
        |=> bit_error_test_clock_enable == $past(pwdata[0]))
        else $error("Test clock enable does not follow the written value");

    AST_ERR_SEL: assert property (@(posedge pclk) disable iff (!presetn) // R09
        st.test_ctrl[6:4] == 3'h2 |=> selected_error_count == $past(lane_error_counts[71:48]))
        else $error("Selector code two does not report lane two count");

endmodule

`default_nettype wire

// file: jrx_tx_model.sv
// Purpose: Far-side stand-in that feeds lanes and multiframe ticks to the sync block
// Assumes: Lane words advance on every pclk; a multiframe tick comes every PERIOD cycles
// Notes: Measures every low period of the sync request output

`timescale 1ns/100ps
`default_nettype none

module jrx_tx_model #(
    parameter int PERIOD = 6,
    parameter int FRAME = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sync_request_output_n,
    output logic [255:0] physical_serial_lane_input,
    output logic [5:0] frame_octets,
    output logic lmfc_pulse,
    output logic low_done,
    output logic [7:0] low_len
);
    logic [23:0] tick;
    logic [7:0] low_cnt;

    assign frame_octets = 6'(FRAME);

    // Lane number plus a running count, so a wrong route or stale word shows at once
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            physical_serial_lane_input[32*n +: 32] = {8'(n), tick};
        end
    end

    // Multiframe tick, and a count of sync low cycles reported when it rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 24'h00_0000;
            lmfc_pulse <= 1'b0;
            low_done <= 1'b0;
            low_len <= 8'h00;
            low_cnt <= 8'h00;
        end else begin
            tick <= tick + 24'h00_0001;
            lmfc_pulse <= (int'(tick) % PERIOD) == 0;
            low_done <= 1'b0;
            if (!sync_request_output_n) begin
                low_cnt <= low_cnt + 8'h01;
            end else if (low_cnt != 8'h00) begin
                low_done <= 1'b1;
                low_len <= low_cnt;
                low_cnt <= 8'h00;
            end
        end
    end
endmodule

`default_nettype wire

// file: serial_rx_sync_status_bench.sv
// Purpose: Self-checking bench for the receive lane status and sync block
// Assumes: Zero-wait APB slave, frame of four octets, multiframe of six cycles
// Notes: Reads and sync low lengths are queued by the driver and checked by a monitor

`timescale 1ns/100ps
`default_nettype none

module serial_rx_sync_status_bench;
    localparam int FO = 4;
    localparam int PER = 6;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, test_en, sync_n, irq;
    logic lmfc, low_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, p;
    logic [7:0] full, empty, low_len, f, e, d;
    logic [3:0] ev;
    logic [5:0] fo;
    logic [255:0] phys, logical;
    logic [191:0] errs;
    logic [23:0] selcnt;
    logic [32:0] exp_rd[$];
    logic [7:0] exp_low[$];
    logic [9:0] ridx[12] = '{10'h308, 10'h309, 10'h30A, 10'h30B, 10'h30C, 10'h30D,
        10'h311, 10'h312, 10'h315, 10'h316, 10'h320, 10'h321};
    logic [7:0] rval[12] = '{8'h08, 8'h1A, 8'h2C, 8'h3E, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int error_cnt, checks_done, seed, sl;

    jrx_sync_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lane_fifo_full(full), .lane_fifo_empty(empty),
        .frame_align_loss(ev[0]), .multiframe_align_loss(ev[1]), .link_sync_request(ev[2]),
        .error_report(ev[3]), .frame_octets(fo), .lmfc_pulse(lmfc),
        .physical_serial_lane_input(phys), .logical_lane_data(logical),
        .lane_error_counts(errs), .selected_error_count(selcnt),
        .bit_error_test_clock_enable(test_en), .sync_request_output_n(sync_n), .irq(irq));

    jrx_tx_model #(.PERIOD(PER), .FRAME(FO)) tx (.pclk(pclk), .presetn(presetn),
        .sync_request_output_n(sync_n), .physical_serial_lane_input(phys),
        .frame_octets(fo), .lmfc_pulse(lmfc), .low_done(low_done), .low_len(low_len));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Monitor: an unexpected sync low compares against zero and so fails
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_rd.size() > 0) begin
            chk({pslverr, prdata}, exp_rd.pop_front());
        end
        if (low_done) begin
            chk(low_len, (exp_low.size() > 0) ? exp_low.pop_front() : 8'h00);
        end
    end

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
        input logic [32:0] exp);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        if (!wr) exp_rd.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            tally_and_finish;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle deframer event, then wait for the sync low to end
    task automatic fire(input int k, input int len);
        int n;
        if (len > 0) exp_low.push_back(8'(len));
        @(posedge pclk);
        ev[k] <= 1'b1;
        @(posedge pclk);
        ev <= 4'h0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (low_done !== 1'b1 && n < 60);
        if (len > 0 && n >= 60) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        #400000;
        error_cnt++;
        tally_and_finish;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 28085;
        {presetn, psel, penable, pwrite, paddr, pwdata, full, empty, ev} = '0;
        for (int i = 0; i < 6; i++) errs[32*i +: 32] = $random(seed);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ridx[i]) apb(1'b0, ridx[i], 8'h00, {25'h0, rval[i]});
        apb(1'b0, 10'h3FF, 8'h00, 33'h1_0000_0000);
        // Live flags: same value twice, a write to read-only ignored
        for (int i = 0; i < 3; i++) begin
            f = 8'($random(seed));
            e = 8'($random(seed));
            full <= f;
            empty <= e;
            apb(1'b1, 10'h30C, 8'hFF, 33'h0);
            apb(1'b0, 10'h30C, 8'h00, {25'h0, f});
            apb(1'b0, 10'h30C, 8'h00, {25'h0, f});
            apb(1'b0, 10'h30D, 8'h00, {25'h0, e});
        end
        full <= 8'h00;
        apb(1'b1, 10'h311, 8'hFF, 33'h0);
        apb(1'b0, 10'h311, 8'h00, 33'h0_0000_0007);
        // Sync low lengths for mask codes 0, 1, 4 and 5 at three duration settings
        foreach (rval[i]) if (i < 3) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h1A : 8'hFF;
            sl = (5 * FO + 9 + 3) / 4 + int'(d[3:0]);
            apb(1'b1, 10'h312, d, 33'h0);
            apb(1'b0, 10'h312, 8'h00, {25'h0, d});
            fire(2, sl);
            fire(3, 1 + int'(d[7:4]));
            for (int m = 0; m < 8; m += 4) begin
                for (int b = 0; b < 2; b++) begin
                    apb(1'b1, 10'h311, 8'(m + b), 33'h0);
                    fire(0, b ? sl : 0);
                    fire(1, m ? sl : 0);
                end
            end
        end
        apb(1'b0, 10'h313, 8'h00, PER);
        apb(1'b1, 10'h315, 8'h01, 33'h0);
        @(posedge pclk);
        chk(test_en, 1'b1);
        apb(1'b1, 10'h315, 8'h00, 33'h0);
        @(posedge pclk);
        chk(test_en, 1'b0);
        // Error count selector and crossbar over every code
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 10'h316, {1'b0, 3'(k), 4'h0}, 33'h0);
            @(posedge pclk);
            @(posedge pclk);
            chk(selcnt, errs[24*k +: 24]);
            apb(1'b1, 10'h308, {2'b00, 3'd1, 3'(k)}, 33'h0);
            @(posedge pclk);
            p = phys[32*k +: 32];
            @(posedge pclk);
            chk(logical[31:0], p);
        end
        // Interrupt: raise, mask, clear
        apb(1'b1, 10'h320, 8'hFF, 33'h0);
        apb(1'b0, 10'h320, 8'h00, 33'h0);
        apb(1'b1, 10'h321, 8'h01, 33'h0);
        apb(1'b1, 10'h311, 8'h01, 33'h0);
        fire(0, sl);
        chk(irq, 1'b1);
        apb(1'b0, 10'h320, 8'h00, 33'h0_0000_0001);
        apb(1'b1, 10'h321, 8'h00, 33'h0);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, 10'h321, 8'h01, 33'h0);
        apb(1'b1, 10'h320, 8'h01, 33'h0);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, 10'h320, 8'h00, 33'h0);
        tally_and_finish;
    end
endmodule

`default_nettype wire
